/* File: common/mpl_cfg.svh */
// Purpose: constants for the motor protection logic
// Assumes: 32-bit AHB-Lite register words, byte addresses
// Notes:   bit positions follow the control register layouts
`ifndef MPL_CFG_SVH
`define MPL_CFG_SVH
// register byte addresses
`define MPL_ADDR_W        8
`define MPL_OFF_PTC       8'h00
`define MPL_OFF_PMC       8'h04
`define MPL_OFF_PAT       8'h08
`define MPL_OFF_MCF       8'h0C
`define MPL_OFF_STAT      8'h10
`define MPL_HSIZE_WORD    3'h2
// reset values
`define MPL_PTC_RST       8'h00
`define MPL_PMC_RST       7'h00
`define MPL_PAT_RST       6'h00
`define MPL_MCF_RST       1'h0
// protection_trigger_control fields
`define MPL_PTC_OCSE      0
`define MPL_PTC_OCWE      1
`define MPL_PTC_LIMHE     2
`define MPL_PTC_OCHE      3
`define MPL_PTC_CMPHE     4
`define MPL_PTC_OVFHE     5
`define MPL_PTC_SWEN      6
`define MPL_PTC_SWDAT     7
// protection_mode_control fields
`define MPL_PMC_OVFPS     0
`define MPL_PMC_CMPPS     1
`define MPL_PMC_OVERCURRENT_OUTPUT_PATTERN      2
`define MPL_PMC_LIMPS     3
`define MPL_PMC_SWPS      4
`define MPL_PMC_CYCE      5
`define MPL_PMC_SRCSEL    6
// gate patterns, order {cb,ct,bb,bt,ab,at}
`define MPL_GATE_BRAKE    6'h2A
`define MPL_GATE_FREE     6'h00
// over-current comparator filter span in system clocks
`define MPL_OC_FILT_CLKS  2
`endif

/* File: common/mpl_pkg.sv */
// Purpose: shared types of the motor protection logic
// Assumes: nothing beyond the cfg header
// Notes:   gate order {cb,ct,bb,bt,ab,at}
`default_nettype none
package mpl_pkg;
   typedef logic [5:0] mpl_gate_t;
   typedef enum logic {MPL_FAULT, MPL_PAUSE} mpl_mode_t;
endpackage : mpl_pkg
`default_nettype wire

/* File: common/mpl_trig_if.sv */
// Purpose: trigger signals from the input filter to the protection core
// Assumes: single clock domain hclk
// Notes:   pulses last one cycle
`default_nettype none
interface mpl_trig_if;
   logic oc_level;
   logic oc_pulse;
   logic cmp1_rise;
   modport src (output oc_level, output oc_pulse, output cmp1_rise);
   modport dst (input oc_level, input oc_pulse, input cmp1_rise);
endinterface : mpl_trig_if
`default_nettype wire

/* File: hdl/mpl_trig_filter.sv */
// Purpose: synchronise comparator pins, filter over-current, find edges
// Assumes: raw comparator pins are asynchronous to hclk
// Notes:   filter output changes only after a stable span of samples
`include "mpl_cfg.svh"
`default_nettype none
module mpl_trig_filter #(
   parameter int FILT_CLKS = `MPL_OC_FILT_CLKS
)(
   input  wire logic     hclk,
   input  wire logic     hresetn,
   input  wire logic     oc_comp_raw,
   input  wire logic     cmp1_raw,
   mpl_trig_if.src       trig
);
   import mpl_pkg::*;
   logic                 oc_m, oc_s, cm_m, cm_s, cm_q;
   logic [FILT_CLKS-1:0] oc_hist;
   logic                 oc_lvl;

   initial
   begin
      if (FILT_CLKS < 1)
         $error("filter span must be at least one clock");
   end

   ////////////////////////////////////////////////////////////////////
   // two-flop synchronisers; first flops feed only the second
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         {oc_m, oc_s, cm_m, cm_s, cm_q} <= 5'h0_0;
      end
      else
      begin
         oc_m <= oc_comp_raw;
         oc_s <= oc_m;
         cm_m <= cmp1_raw;
         cm_s <= cm_m;
         cm_q <= cm_s;
      end
   end

   // level follows only a full span of equal samples, so noise is dropped
   wire all_hi = &{oc_hist, oc_s};  // [R06]
   wire all_lo = ~|{oc_hist, oc_s};
   wire next_lvl = all_hi ? 1'b1 : (all_lo ? 1'b0 : oc_lvl);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         oc_hist        <= '0;
         oc_lvl         <= 1'b0;
         trig.oc_pulse  <= 1'b0;
         trig.cmp1_rise <= 1'b0;
      end
      else
      begin
         oc_hist        <= FILT_CLKS'({oc_hist, oc_s});  // oldest drops
         oc_lvl         <= next_lvl;
         trig.oc_pulse  <= next_lvl & ~oc_lvl;  // [R06]
         trig.cmp1_rise <= cm_s & ~cm_q;
      end
   end
   assign trig.oc_level = oc_lvl;

   ////////////////////////////////////////////////////////////////////
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   chk_filter_span: assert property (  // [R06]
      $rose(oc_lvl) |-> $past(oc_s) && $past(oc_hist[0]))
      else $error("over-current level rose without a stable span");
   cov_oc_pulse: cover property (trig.oc_pulse);
endmodule : mpl_trig_filter
`default_nettype wire

/* File: hdl/mpl_top.sv */
// Purpose: motor protection logic with AHB-Lite control registers
// Assumes: trigger events from same-clock logic, comparators on pins
// Notes:   gate outputs and protect are registered; reads take one wait
//
// Summary of operation
// R01: protect forces brake or free-run gate pattern
// R02: fault mode protect follows live trigger condition
// R03: pause mode protect held until software release
// R04: override replaces drive with preset six-bit pattern
// R05: override cleared only by software action
// R06: over-current comparator filtered over two clocks
// R07: software should use fault mode for over-current
// R08: current limit triggers only when enabled
// R09: current limit works only with opamp channel
// R10: limit restart immediate or next PWM period
// R11: over-current enable and fault/pause mode select
// R12: hardware override latches the over-current pulse
// R13: software enables over-current before hardware override
// R14: hardware override released by enable low-high toggle
// R15: software override bit sets and clears directly
// R16: compare stall triggers when enabled, pause mode
// R17: overflow stall triggers when enabled, pause mode
// R18: software data triggers pause, releases in both
// R19: software enable 1-0-1 releases software protection
// R20: source select picks filtered pulse or comparator edge
// R21: cycle-by-cycle off, recover next period, repeat
// R22: all control bits reset to zero
`include "mpl_cfg.svh"
`default_nettype none
module mpl_top #(
   parameter int FILT_CLKS = `MPL_OC_FILT_CLKS
)(
   input  wire logic               hclk,
   input  wire logic               hresetn,
   input  wire logic               hsel,
   input  wire logic [31:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic [31:0]        hwdata,
   input  wire logic               hready,
   output logic      [31:0]        hrdata,
   output logic                    hreadyout,
   output logic                    hresp,
   input  wire logic               oc_comp_raw,
   input  wire logic               cmp1_raw,
   input  wire logic               current_limit_event,
   input  wire logic               capture_compare_stall,
   input  wire logic               capture_overflow_stall,
   input  wire logic               adc_sel_opamp,
   input  wire logic               pwm_period_start,
   input  wire mpl_pkg::mpl_gate_t drive_in,
   output mpl_pkg::mpl_gate_t      gate_out,
   output logic                    protect,
   output logic                    overcurrent_output_override
);
   import mpl_pkg::*;

   logic [7:0]             protection_trigger_control;
   logic [6:0]             protection_mode_control;
   mpl_gate_t              overcurrent_output_pattern;
   logic                   motor_config_reg;
   logic                   wr_pend, rd_pend;
   logic [`MPL_ADDR_W-1:0] a_q;
   logic                   pause_q, lim_hold, cyc_off, hw_ov;
   mpl_trig_if             trig ();

   ////////////////////////////////////////////////////////////////////
   // input synchronising and over-current filtering
   mpl_trig_filter #(.FILT_CLKS(FILT_CLKS)) u_filt (
      .hclk        (hclk),
      .hresetn     (hresetn),
      .oc_comp_raw (oc_comp_raw),
      .cmp1_raw    (cmp1_raw),
      .trig        (trig)
   );

   ////////////////////////////////////////////////////////////////////
   // bus decode; only whole-word writes are accepted
   wire addr_ok = hsel & hready & htrans[1];
   wire wr_ptc  = wr_pend & (a_q == `MPL_OFF_PTC);
   wire wr_pmc  = wr_pend & (a_q == `MPL_OFF_PMC);
   wire wr_pat  = wr_pend & (a_q == `MPL_OFF_PAT);
   wire wr_mcf  = wr_pend & (a_q == `MPL_OFF_MCF);
   wire [7:0] ptc = protection_trigger_control;
   wire [6:0] pmc = protection_mode_control;

   // status word shows the block's live protection state
   wire [31:0] stat_word = {26'h000_0000, hw_ov, cyc_off, lim_hold,
                            pause_q, overcurrent_output_override, protect};
   wire [31:0] rd_mux =
      (a_q == `MPL_OFF_PTC)  ? {24'h00_0000, ptc} :
      (a_q == `MPL_OFF_PMC)  ? {25'h000_0000, pmc} :
      (a_q == `MPL_OFF_PAT)  ? {26'h000_0000, overcurrent_output_pattern} :
      (a_q == `MPL_OFF_MCF)  ? {31'h0000_0000, motor_config_reg} :
      (a_q == `MPL_OFF_STAT) ? stat_word : 32'h0000_0000;

   // read takes one wait so data written just before is seen
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend   <= 1'b0;
         rd_pend   <= 1'b0;
         a_q       <= '0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h0000_0000;
      end
      else
      begin
         wr_pend   <= addr_ok & hwrite & (hsize == `MPL_HSIZE_WORD);
         rd_pend   <= addr_ok & ~hwrite;
         if (addr_ok)
            a_q <= haddr[`MPL_ADDR_W-1:0];
         hreadyout <= ~(addr_ok & ~hwrite);
         if (rd_pend)
            hrdata <= rd_mux;
      end
   end

   // control registers, all cleared by reset
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         protection_trigger_control <= `MPL_PTC_RST;  // [R22]
         protection_mode_control    <= `MPL_PMC_RST;  // [R22]
         overcurrent_output_pattern <= `MPL_PAT_RST;
         motor_config_reg           <= `MPL_MCF_RST;
      end
      else
      begin
         if (wr_ptc)
            protection_trigger_control <= hwdata[7:0];
         if (wr_pmc)
            protection_mode_control <= hwdata[6:0];
         if (wr_pat)
            overcurrent_output_pattern <= hwdata[5:0];
         if (wr_mcf)
            motor_config_reg <= hwdata[0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // software edges are taken from the write itself, no extra history
   wire ocse_rise = wr_ptc & hwdata[`MPL_PTC_OCSE]
                    & ~ptc[`MPL_PTC_OCSE];  // [R14]
   wire swen_rise = wr_ptc & hwdata[`MPL_PTC_SWEN]
                    & ~ptc[`MPL_PTC_SWEN];  // [R19]
   wire swd_fall  = wr_ptc & hwdata[`MPL_PTC_SWEN]
                    & ptc[`MPL_PTC_SWDAT]
                    & ~hwdata[`MPL_PTC_SWDAT];  // [R18]
   wire sw_release = swen_rise | swd_fall;

   // enabled hardware sources
   wire oc_en   = ptc[`MPL_PTC_OCHE];  // [R11]
   wire cmp_hit = capture_compare_stall & ptc[`MPL_PTC_CMPHE];  // [R16]
   wire ovf_hit = capture_overflow_stall & ptc[`MPL_PTC_OVFHE];  // [R17]
   wire lim_act = current_limit_event & ptc[`MPL_PTC_LIMHE]
                  & adc_sel_opamp;  // [R08] [R09]
   // the old data bit still reads 1 during its own clearing write, so
   // that write must not count as a trigger or the release is lost
   wire sw_trig = ptc[`MPL_PTC_SWEN] & ptc[`MPL_PTC_SWDAT]
                  & pmc[`MPL_PMC_SWPS] & ~swd_fall;  // [R18]

   // pause sources latch; set wins over a release in the same cycle
   wire pause_set =
      (trig.oc_pulse & oc_en & pmc[`MPL_PMC_OVERCURRENT_OUTPUT_PATTERN])  // [R11]
      | (cmp_hit & pmc[`MPL_PMC_CMPPS])  // [R16]
      | (ovf_hit & pmc[`MPL_PMC_OVFPS])  // [R17]
      | sw_trig;
   wire next_pause = pause_set | (pause_q & ~sw_release);  // [R03]

   // limit hold waits for a period start when restart is deferred
   wire next_lim_hold = lim_act
      | (lim_hold & pmc[`MPL_PMC_LIMPS] & ~pwm_period_start);  // [R10]

   // cycle-by-cycle: a still-high level sets it again at period start
   wire next_cyc = (trig.oc_level & pmc[`MPL_PMC_CYCE])
      | (cyc_off & ~pwm_period_start);  // [R21]

   // fault sources are live and drop once clear; cycle-by-cycle and deferred limit holds wait for a period start
   wire fault_live =
      (trig.oc_level & oc_en & ~pmc[`MPL_PMC_OVERCURRENT_OUTPUT_PATTERN])  // [R02] [R11]
      | (cmp_hit & ~pmc[`MPL_PMC_CMPPS])
      | (ovf_hit & ~pmc[`MPL_PMC_OVFPS])
      | next_lim_hold | next_cyc;  // [R02]
   wire next_protect = fault_live | next_pause;

   // hardware override source and latch, released only by software
   wire ov_trig = pmc[`MPL_PMC_SRCSEL] ? trig.cmp1_rise
                                       : trig.oc_pulse;  // [R20]
   wire next_hw_ov = (ov_trig & (ptc[`MPL_PTC_OCSE] | ocse_rise))  // [R12]
                     | (hw_ov & ~ocse_rise);  // [R05] [R14]
   wire next_ov = next_hw_ov | ptc[`MPL_PTC_OCWE];  // [R15]

   // output selection: override beats protect beats normal drive
   wire [5:0] prot_pat = motor_config_reg ? `MPL_GATE_BRAKE
                                          : `MPL_GATE_FREE;  // [R01]
   wire [5:0] next_gate = next_ov ? overcurrent_output_pattern  // [R04]
                        : next_protect ? prot_pat : drive_in;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pause_q                     <= 1'b0;
         lim_hold                    <= 1'b0;
         cyc_off                     <= 1'b0;
         hw_ov                       <= 1'b0;
         protect                     <= 1'b0;
         overcurrent_output_override <= 1'b0;
         gate_out                    <= `MPL_GATE_FREE;
      end
      else
      begin
         pause_q                     <= next_pause;
         lim_hold                    <= next_lim_hold;
         cyc_off                     <= next_cyc;
         hw_ov                       <= next_hw_ov;
         protect                     <= next_protect;
         overcurrent_output_override <= next_ov;
         gate_out                    <= next_gate;
      end
   end

   ////////////////////////////////////////////////////////////////////
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   chk_protect_gate_state: assert property (  // [R01]
      protect && !overcurrent_output_override |->
      gate_out == ($past(motor_config_reg) ? `MPL_GATE_BRAKE
                                            : `MPL_GATE_FREE))
      else $error("protect pattern wrong");
   chk_fault_auto_release: assert property (  // [R02]
      !fault_live && !next_pause |=> !protect)
      else $error("fault protect not released");
   chk_pause_hold_state: assert property (  // [R03]
      pause_q && !sw_release |=> pause_q && protect)
      else $error("pause protect lost without release");
   chk_override_pattern_out: assert property (  // [R04]
      overcurrent_output_override |->
      gate_out == $past(overcurrent_output_pattern))
      else $error("override pattern not driven");
   chk_override_sticky: assert property (  // [R05]
      hw_ov && !ocse_rise |=> hw_ov [*2] or
      (hw_ov ##1 $past(ocse_rise)))
      else $error("override dropped without software");
   chk_override_release: assert property (  // [R14]
      ocse_rise && !ov_trig |=> !hw_ov)
      else $error("override not released by toggle");
   chk_sw_override_set: assert property (  // [R15]
      ptc[`MPL_PTC_OCWE] |=> overcurrent_output_override)
      else $error("software override not applied");
   chk_limit_disabled: assert property (  // [R08]
      !ptc[`MPL_PTC_LIMHE] && !lim_hold |=> !lim_hold)
      else $error("disabled limit path triggered");
   chk_limit_restart_now: assert property (  // [R10]
      !lim_act && !pmc[`MPL_PMC_LIMPS] |=> !lim_hold)
      else $error("immediate restart delayed");
   chk_cycle_recover: assert property (  // [R21]
      cyc_off && pwm_period_start && !trig.oc_level |=> !cyc_off)
      else $error("cycle-by-cycle did not recover");

   cov_pause_release: cover property (pause_q ##1 !pause_q);
   cov_hw_override: cover property ($rose(hw_ov));
   cov_brake: cover property (protect && motor_config_reg);
   cov_read_wait: cover property (!hreadyout ##1 hreadyout);
endmodule : mpl_top
`default_nettype wire

/* File: test/mpl_bridge_model.sv */
// Purpose: power bridge stand-in that senses winding current
// Assumes: gate order {cb,ct,bb,bt,ab,at}, all high active
// Notes:   the sense comparator only sees current while a leg conducts
`default_nettype none
module mpl_bridge_model (
   input  wire logic               hclk,
   input  wire mpl_pkg::mpl_gate_t gate,
   input  wire logic               short_cmd,
   output logic                    oc_sense,
   output logic                    shoot_thru
);
   timeunit 1ns;
   timeprecision 1ps;
   import mpl_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // an overload only shows while some switch is on, so the sense line
   // drops by itself once the drive is forced off
   assign oc_sense = short_cmd & (|gate);

   // sticky flag: both switches of one leg on would short the supply
   initial shoot_thru = 1'b0;
   always @(posedge hclk)
   begin
      if ((gate[5] & gate[4]) | (gate[3] & gate[2]) | (gate[1] & gate[0]))
         shoot_thru <= 1'b1;
   end
endmodule : mpl_bridge_model
`default_nettype wire

/* File: test/motor_protection_logic_tb_top.sv */
// Purpose: self-checking bench for the motor protection logic
// Assumes: one AHB-Lite master, hready looped from hreadyout
// Notes:   register model and expected gates are kept in the bench
`include "mpl_cfg.svh"
`default_nettype none
module motor_protection_logic_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import mpl_pkg::*;

   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic        hreadyout, hresp, oc_raw, cmp1_raw = 0, limit = 0;
   logic        adc_sel = 0, short_cmd = 0, protect, ovr, shoot;
   logic [2:0]  ev = 3'h0;   // {period start, overflow, compare}
   mpl_gate_t   drive_in = 6'h01, gate_out;
   int          num_errors = 0, n_tests = 0;
   int          m_reg [4] = '{0, 0, 0, 0};
   int          mask [4] = '{255, 127, 63, 1};

   always #5 hclk = ~hclk;

   mpl_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .oc_comp_raw(oc_raw), .cmp1_raw(cmp1_raw),
      .current_limit_event(limit), .capture_compare_stall(ev[0]),
      .capture_overflow_stall(ev[1]), .adc_sel_opamp(adc_sel),
      .pwm_period_start(ev[2]), .drive_in(drive_in), .gate_out(gate_out),
      .protect(protect), .overcurrent_output_override(ovr));

   mpl_bridge_model bridge (.hclk(hclk), .gate(gate_out),
      .short_cmd(short_cmd), .oc_sense(oc_raw), .shoot_thru(shoot));

   ////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : finish_test

   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         $display("BAD %s expected %h seen %h", what, exp, seen);
         num_errors++;
      end
   endtask : check

   // a lost handshake ends the run rather than hanging it
   task automatic wait_ready();
      int k;
      for (k = 0; k < 20; k++)
      begin
         @(posedge hclk);
         if (hreadyout === 1'b1)
            break;
      end
      if (k == 20)
      begin
         $display("BAD bus handshake timed out");
         num_errors++;
         finish_test();
      end
   endtask : wait_ready

   task automatic bus(logic wr, logic [7:0] a, logic [31:0] d,
                      output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
      rd = hrdata;
      check("hresp", {31'h0, hresp}, 32'h0);
   endtask : bus

   task automatic wr(int idx, int d);
      logic [31:0] rd;
      bus(1'b1, 8'(idx * 4), d, rd);
      m_reg[idx] = d & mask[idx];
   endtask : wr

   task automatic rdchk(logic [7:0] a, logic [31:0] exp);
      logic [31:0] rd;
      bus(1'b0, a, 32'h0, rd);
      check("register read", rd, exp);
   endtask : rdchk

   task automatic step(int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask : step

   task automatic pulse(logic [2:0] b);
      @(posedge hclk);
      ev <= b;
      @(posedge hclk);
      ev <= 3'h0;
      #1;
   endtask : pulse

   // expected drive: override first, then protect state, then normal
   task automatic outs(logic p, logic o);
      logic [5:0] g;
      g = p ? (m_reg[3][0] ? `MPL_GATE_BRAKE : `MPL_GATE_FREE) : drive_in;
      g = o ? m_reg[2][5:0] : g;
      check("protect", {31'h0, protect}, {31'h0, p});
      check("override", {31'h0, ovr}, {31'h0, o});
      check("gate", {26'h0, gate_out}, {26'h0, g});
   endtask : outs

   task automatic wait_for(bit on_ovr, logic v);
      int k;
      for (k = 0; k < 30; k++)
      begin
         step(1);
         if ((on_ovr ? ovr : protect) === v)
            break;
      end
      check("wait", k < 30, 1);
      if (k == 30)
         finish_test();
   endtask : wait_for

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      int seed;
      seed = $urandom(32'hb25455e7);
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      // high sides only, so the bridge never sees a leg shorted
      drive_in <= 6'($urandom & 6'h15) | 6'h01;
      step(2);
      outs(0, 0);
      for (int i = 0; i < 4; i++)
         rdchk(8'(i * 4), 32'h0);
      rdchk(8'h20, 32'h0);
      wr(3, 1);
      wr(1, 8'h02);
      wr(0, 8'h10);
      pulse(3'h1);
      outs(1, 0);
      step(5);
      outs(1, 0);
      wr(0, 8'h50);
      step(1);
      outs(0, 0);
      wr(3, 0);
      wr(1, 8'h01);
      wr(0, 8'h00);
      pulse(3'h2);
      outs(0, 0);
      wr(0, 8'h20);
      pulse(3'h2);
      outs(1, 0);
      wr(0, 8'h60);
      step(1);
      outs(0, 0);
      // current limit: enable, channel select, then both restart kinds
      wr(1, 0);
      wr(0, 0);
      adc_sel <= 1'b1;
      limit <= 1'b1;
      step(2);
      outs(0, 0);
      adc_sel <= 1'b0;
      wr(0, 8'h04);
      step(1);
      outs(0, 0);
      adc_sel <= 1'b1;
      step(1);
      outs(1, 0);
      limit <= 1'b0;
      step(1);
      outs(0, 0);
      wr(1, 8'h08);
      limit <= 1'b1;
      step(1);
      outs(1, 0);
      limit <= 1'b0;
      step(3);
      outs(1, 0);
      pulse(3'h4);
      outs(0, 0);
      wr(0, 0);
      wr(2, $urandom & 6'h2A);
      wr(0, 8'h02);
      step(1);
      outs(0, 1);
      wr(0, 0);
      step(1);
      outs(0, 0);
      wr(1, 8'h10);
      wr(0, 8'hC0);
      step(1);
      outs(1, 0);
      wr(0, 8'h40);
      step(1);
      outs(0, 0);
      // over-current pin: a one-cycle glitch must not get through
      wr(1, 8'h04);
      wr(0, 8'h08);
      short_cmd <= 1'b1;
      step(1);
      short_cmd <= 1'b0;
      step(10);
      outs(0, 0);
      short_cmd <= 1'b1;
      wait_for(0, 1);
      short_cmd <= 1'b0;
      step(6);
      outs(1, 0);
      wr(0, 8'h48);
      step(1);
      outs(0, 0);
      wr(1, 0);
      wr(0, 8'h08);
      short_cmd <= 1'b1;
      wait_for(0, 1);
      short_cmd <= 1'b0;
      wait_for(0, 0);
      wr(2, $urandom & 6'h2A);
      wr(0, 8'h09);
      short_cmd <= 1'b1;
      wait_for(1, 1);
      short_cmd <= 1'b0;
      step(12);
      outs(0, 1);
      wr(0, 8'h08);
      step(2);
      outs(0, 1);
      wr(0, 8'h09);
      step(1);
      outs(0, 0);
      wr(1, 8'h40);
      cmp1_raw <= 1'b1;
      wait_for(1, 1);
      cmp1_raw <= 1'b0;
      wr(0, 8'h08);
      wr(0, 8'h09);
      step(1);
      outs(0, 0);
      // cycle-by-cycle: drive stays off until a period start, level low
      wr(0, 0);
      wr(1, 8'h20);
      short_cmd <= 1'b1;
      wait_for(0, 1);
      short_cmd <= 1'b0;
      step(8);
      outs(1, 0);
      pulse(3'h4);
      outs(0, 0);
      // read back what software last wrote
      for (int i = 0; i < 4; i++)
         rdchk(8'(i * 4), m_reg[i]);
      check("shoot through", {31'h0, shoot}, 32'h0);
      finish_test();
   end
endmodule : motor_protection_logic_tb_top
`default_nettype wire
